/* core/gpev_top.sv */
// Pin configuration registers on AHB-Lite and twelve general purpose pins with event outputs.
// Notes on behaviour
// - Bits 15:14 let pins 9 and 8 carry clock compare events.
// - Enable 0 keeps events off the pin; 1 drives them on.
// - Event enable forces the pin to output; buffer type still applies.
// - Bit 13, reset 1, sets pin 9 event level: 0 low, 1 high.
// - Bit 12, reset 1, sets pin 8 event level: 0 low, 1 high.
// - Bits 11:0, reset 0, pick open-drain (0) or push/pull (1).
// - Open-drain active-low event pin pulls low during event, else floats.
// - Direction bits 27:16, reset 0: 0 input, 1 output.
`timescale 1ns/1ns
`default_nettype none
`include "gpev_map.svh"
module gpev_top #(
  parameter int NPINS = `GPEV_NPINS
) (
  // Clock and reset.
  input  wire logic              CLK_I,
  input  wire logic              SRST_I,
  // AHB-Lite slave.
  input  wire logic              HSEL_I,
  input  wire logic [11:0]       HADDR_I,
  input  wire logic [1:0]        HTRANS_I,
  input  wire logic              HWRITE_I,
  input  wire logic [2:0]        HSIZE_I,
  input  wire logic [31:0]       HWDATA_I,
  input  wire logic              HREADY_I,
  output logic      [31:0]       HRDATA_O,
  output logic                   HREADYOUT_O,
  output logic                   HRESP_O,
  // Compare events from the time stamp unit, bit 1 for pin 9, bit 0 for pin 8.
  input  wire logic [1:0]        EVENT_I,
  // Pins.
  input  wire logic [NPINS-1:0]  PIN_I,
  output logic      [NPINS-1:0]  PIN_O,
  output logic      [NPINS-1:0]  PIN_OE_O
);

  ////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    logic [31:0]          cfg;
    logic [31:0]          data_dir;
    logic [NPINS-1:0]     pin_meta;
    logic [NPINS-1:0]     pin_sync;
    gpev_pkg::gpev_phase_e phase;
    logic                 wr;
    logic [11:0]          addr;
    logic [31:0]          rdata;
  } gpev_state_s;

  gpev_state_s st;
  gpev_state_s next_st;

  logic [NPINS-1:0] pin_direction;
  logic [NPINS-1:0] pin_data;
  logic [NPINS-1:0] pin_buffer_type;
  logic [1:0]       event_en;
  logic             pin9_event_polarity;
  logic             pin8_event_polarity;
  logic [NPINS-1:0] eff_dir;
  logic [31:0]      rd_value;
  logic             start;

  // Word read value, also used for readback of the data field.
  function automatic logic [31:0] read_word(input logic [11:0] a, input gpev_state_s s,
                                            input logic [NPINS-1:0] dir_eff);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      `GPEV_OFS_CFG: begin
        v = s.cfg;
      end
      `GPEV_OFS_DATA_DIR: begin
        v = s.data_dir;
        // Inputs show the synchronised pin, outputs the last written data.
        v[`GPEV_DATA_LSB +: NPINS] = (s.data_dir[`GPEV_DATA_LSB +: NPINS] & dir_eff)
                                   | (s.pin_sync & ~dir_eff);
      end
      default: begin
        v = 32'h0000_0000;
      end
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Field decode.

  // Event enable and polarity fields steer pins 9 and 8.
  assign event_en            = st.cfg[`GPEV_OE_LSB +: 2];
  assign pin9_event_polarity = st.cfg[`GPEV_POL9_BIT];
  assign pin8_event_polarity = st.cfg[`GPEV_POL8_BIT];
  assign pin_buffer_type     = st.cfg[`GPEV_BUF_LSB +: NPINS];
  assign pin_direction       = st.data_dir[`GPEV_DIR_LSB +: NPINS];
  assign pin_data            = st.data_dir[`GPEV_DATA_LSB +: NPINS];

  // Event enables override the direction of pins 9 and 8.
  always_comb begin
    eff_dir    = pin_direction;
    eff_dir[9] = pin_direction[9] | event_en[1];
    eff_dir[8] = pin_direction[8] | event_en[0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave and register update.

  // Read data is taken from the state at the address phase, so a read that follows a write
  // to the same word in the very next cycle still returns the old contents.
  assign start = HSEL_I & HTRANS_I[1] & HREADY_I;
  assign rd_value = read_word({HADDR_I[11:2], 2'b00}, st, eff_dir);

  // Zero wait state slave: writes land in the data phase, reads are latched at address phase.
  always_comb begin
    next_st          = st;
    next_st.pin_meta = PIN_I;
    next_st.pin_sync = st.pin_meta;
    if (st.phase == gpev_pkg::GPEV_DATA && st.wr) begin
      case (st.addr)
        `GPEV_OFS_CFG: begin
          next_st.cfg = HWDATA_I & `GPEV_CFG_WMASK;
        end
        `GPEV_OFS_DATA_DIR: begin
          next_st.data_dir = HWDATA_I & `GPEV_DD_WMASK;
        end
        default: begin
          next_st.cfg = st.cfg;
        end
      endcase
    end
    if (start) begin
      next_st.phase = gpev_pkg::GPEV_DATA;
      next_st.wr    = HWRITE_I;
      next_st.addr  = {HADDR_I[11:2], 2'b00};
      next_st.rdata = HWRITE_I ? st.rdata : rd_value;
    end else begin
      next_st.phase = gpev_pkg::GPEV_IDLE;
      next_st.wr    = 1'b0;
    end
    if (SRST_I) begin
      next_st.cfg      = `GPEV_CFG_RESET;
      next_st.data_dir = `GPEV_DD_RESET;
      next_st.pin_meta = '0;
      next_st.pin_sync = '0;
      next_st.phase    = gpev_pkg::GPEV_IDLE;
      next_st.wr       = 1'b0;
      next_st.addr     = 12'h000;
      next_st.rdata    = 32'h0000_0000;
    end
  end

  // Register the whole state.
  always_ff @(posedge CLK_I) begin
    st <= next_st;
  end

  assign HRDATA_O    = st.rdata;
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O     = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers.

  for (genvar i = 0; i < NPINS; i++) begin : g_pin
    logic ev_en;
    logic ev_pol;
    logic ev;
    if (i == 9) begin : g_p9
      assign ev_en  = event_en[1];
      assign ev_pol = pin9_event_polarity;
      assign ev     = EVENT_I[1];
    end else if (i == 8) begin : g_p8
      assign ev_en  = event_en[0];
      assign ev_pol = pin8_event_polarity;
      assign ev     = EVENT_I[0];
    end else begin : g_pn
      assign ev_en  = 1'b0;
      assign ev_pol = 1'b1;
      assign ev     = 1'b0;
    end
    gpev_pin_drive u_drv (
      .dir_i       (pin_direction[i]),
      .data_i      (pin_data[i]),
      .push_pull_i (pin_buffer_type[i]),
      .event_en_i  (ev_en),
      .event_pol_i (ev_pol),
      .event_i     (ev),
      .pin_o       (PIN_O[i]),
      .pin_oe_o    (PIN_OE_O[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  // Reset is checked one edge after it is sampled, so the unreset power-up state is never seen.
  a_cfg_reset_value: assert property (@(posedge CLK_I)
    SRST_I
      |=> st.cfg == `GPEV_CFG_RESET) else $error("cfg reset wrong");

  // Every pin leaves reset as an undriven input.
  a_dir_reset_zero: assert property (@(posedge CLK_I)
    SRST_I
      |=> PIN_OE_O == '0) else $error("pins driven after reset");

  // A plain input pin never drives.
  a_input_undriven: assert property (@(posedge CLK_I) disable iff (SRST_I)
    !pin_direction[3]
      |-> !PIN_OE_O[3]) else $error("input pin driven");

  // No pin drives unless its direction bit or its event enable makes it an output.
  a_oe_needs_dir: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (PIN_OE_O & ~eff_dir) == '0)
    else $error("pin driven without direction");

  // A push/pull event pin drives whatever its direction bit says, as the event enable forces it out.
  a_event_force_out: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (event_en[1] && pin_buffer_type[9])
      |-> PIN_OE_O[9]) else $error("event not forced out");

  // The same override holds on the lower event pin.
  a_event_en_pin8: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (event_en[0] && pin_buffer_type[8])
      |-> PIN_OE_O[8]) else $error("event not forced out on pin 8");

  // The override keeps the open-drain buffer: an active high event releases the line.
  a_od_event_pol1: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (event_en[1] && !pin_buffer_type[9] && pin9_event_polarity)
      |-> (PIN_OE_O[9] == !EVENT_I[1] && !PIN_O[9])) else $error("od event pol1 wrong");

  // With the enable clear the data bit, not the event, reaches the pin.
  a_event_off_pin: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (!event_en[0] && pin_direction[0+8] && pin_buffer_type[8])
      |-> PIN_O[8] == pin_data[8]) else $error("event leaked onto pin");

  // With the enable clear an input event pin stays undriven.
  a_event_off_pin9: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (!event_en[1] && !pin_direction[9])
      |-> !PIN_OE_O[9]) else $error("event drove input pin 9");

  // Open-drain active low event pulls low only while the event is present.
  a_od_event_low: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (event_en[1] && !pin_buffer_type[9] && !pin9_event_polarity)
      |-> (PIN_OE_O[9] == EVENT_I[1] && !PIN_O[9])) else $error("od event wrong");

  // The same open-drain behaviour on the lower event pin.
  a_od_event_pin8: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (event_en[0] && !pin_buffer_type[8] && !pin8_event_polarity)
      |-> (PIN_OE_O[8] == EVENT_I[0] && !PIN_O[8])) else $error("od event pin 8 wrong");

  // Push/pull event pin shows the polarity-selected level.
  a_pp_event_level: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (event_en[0] && pin_buffer_type[8])
      |-> PIN_O[8] == (EVENT_I[0] ~^ pin8_event_polarity)) else $error("pp event level");

  // The same push/pull level on the upper event pin.
  a_pp_event_pin9: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (event_en[1] && pin_buffer_type[9])
      |-> PIN_O[9] == (EVENT_I[1] ~^ pin9_event_polarity)) else $error("pp event pin 9");

  // Open-drain data pin pulls low for a cleared bit and floats otherwise.
  a_od_data_drive: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (pin_direction[2] && !pin_buffer_type[2])
      |-> (PIN_OE_O[2] == !pin_data[2] && !PIN_O[2])) else $error("od data wrong");

  // Push/pull data pin always drives its data bit.
  a_pp_data_drive: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (pin_direction[5] && pin_buffer_type[5])
      |-> (PIN_OE_O[5] && PIN_O[5] == pin_data[5])) else $error("pp data wrong");

  // A configuration write lands at the end of its data phase.
  a_cfg_write_lands: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (start && HWRITE_I && HADDR_I == `GPEV_OFS_CFG) ##1 !SRST_I
      |=> st.cfg == ($past(HWDATA_I) & `GPEV_CFG_WMASK)) else $error("cfg write lost");

  // A data and direction write lands the same way.
  a_dd_write_lands: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (start && HWRITE_I && HADDR_I == `GPEV_OFS_DATA_DIR) ##1 !SRST_I
      |=> st.data_dir == ($past(HWDATA_I) & `GPEV_DD_WMASK)) else $error("dd write lost");

  // A configuration read returns the contents seen at its address phase.
  a_cfg_read_data: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (start && !HWRITE_I && HADDR_I == `GPEV_OFS_CFG)
      |=> HRDATA_O == $past(st.cfg)) else $error("cfg read data wrong");

  // Read data stands until the next read address phase.
  a_rdata_stands: assert property (@(posedge CLK_I) disable iff (SRST_I)
    !(start && !HWRITE_I)
      |=> $stable(HRDATA_O)) else $error("read data changed");

  // An input pin reads back its synchronised level.
  a_input_readback: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (start && !HWRITE_I && HADDR_I == `GPEV_OFS_DATA_DIR && !eff_dir[0])
      |=> HRDATA_O[0] == $past(st.pin_sync[0])) else $error("input readback wrong");

  // Reserved configuration bits never hold a one.
  a_cfg_reserved: assert property (@(posedge CLK_I) disable iff (SRST_I)
    st.cfg[31:30] == 2'b00)
    else $error("cfg reserved bits set");

  // Reserved data and direction bits never hold a one.
  a_dd_reserved: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (st.data_dir[31:28] == 4'h0 && st.data_dir[15:12] == 4'h0))
    else $error("dd reserved bits set");
endmodule
`default_nettype wire

/* core/gpev_map.svh */
// Register offsets, field positions and reset values for the pin event output block.
`ifndef GPEV_MAP_SVH
`define GPEV_MAP_SVH
`define GPEV_OFS_CFG       12'h1e0
`define GPEV_OFS_DATA_DIR  12'h1e4
`define GPEV_OFS_EVENT_IN  12'h1f0
`define GPEV_NPINS         12
`define GPEV_OE_LSB        14
`define GPEV_POL9_BIT      13
`define GPEV_POL8_BIT      12
`define GPEV_BUF_LSB       0
`define GPEV_DIR_LSB       16
`define GPEV_DATA_LSB      0
`define GPEV_INTPOL_LSB    16
`define GPEV_CLREN_LSB     28
`define GPEV_CFG_RESET     32'h0000_3000
`define GPEV_CFG_WMASK     32'h3fff_ffff
`define GPEV_DD_WMASK      32'h0fff_0fff
`define GPEV_DD_RESET      32'h0000_0000
`endif

/* core/gpev_pkg.sv */
// Types shared by the pin event output block.
package gpev_pkg;
  typedef enum logic [1:0] {
    GPEV_IDLE = 2'b00,
    GPEV_DATA = 2'b01
  } gpev_phase_e;
endpackage

/* core/gpev_pin_drive.sv */
// Output driver of one general purpose pin: direction, event override and buffer type.
`timescale 1ns/1ns
`default_nettype none
module gpev_pin_drive (
  // Configuration.
  input  wire logic dir_i,
  input  wire logic data_i,
  input  wire logic push_pull_i,
  // Event path.
  input  wire logic event_en_i,
  input  wire logic event_pol_i,
  input  wire logic event_i,
  // Pin.
  output logic      pin_o,
  output logic      pin_oe_o
);
  logic drive_out;
  logic level;

  // Event enable forces output but the buffer type still applies.
  always_comb begin
    drive_out = dir_i | event_en_i;
    level     = event_en_i ? (event_i ~^ event_pol_i)
                           : data_i;
    if (!drive_out) begin
      pin_o    = 1'b0;
      pin_oe_o = 1'b0;
    end else if (push_pull_i) begin
      pin_o    = level;
      pin_oe_o = 1'b1;
    end else begin
      pin_o    = 1'b0;
      pin_oe_o = ~level;
    end
  end
endmodule
`default_nettype wire

/* testbench/gpev_pin_load.sv */
// External circuitry on the pins: a pull-up on every line, read back by the block.
`timescale 1ns/1ns
`default_nettype none
module gpev_pin_load (
  // Block side.
  input  wire logic [11:0] pin_o_i,
  input  wire logic [11:0] pin_oe_i,
  // Resolved wire.
  output logic      [11:0] pin_i_o
);
  // A released line floats to the pull-up, so an undriven pin is never read as a stale value.
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      pin_i_o[i] = pin_oe_i[i] ? pin_o_i[i] : 1'b1;
    end
  end
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench: random pin setups compared with a reference model.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hrdy, hresp;
  logic [11:0] haddr = 12'h000, pin_i, pin_o, pin_oe;
  logic [1:0]  htrans = 2'h0, ev = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, rd, cfg, dd, e;
  integer      mismatches = 0, compares = 0, seed = 83885, cyc = 0;
  gpev_top u_dut (.CLK_I(clk), .SRST_I(srst), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
    .HREADY_I(hrdy), .HRDATA_O(hrdata), .HREADYOUT_O(hrdy), .HRESP_O(hresp),
    .EVENT_I(ev), .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE_O(pin_oe));
  gpev_pin_load u_load (.pin_o_i(pin_o), .pin_oe_i(pin_oe), .pin_i_o(pin_i));
  ////////////////////////////////////////////////////////////////////////////
  // Clock and a hang guard sized well above the planned run.
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    compares = compares + 1;
    if (g !== x) begin
      mismatches = mismatches + 1;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // One AHB-Lite single word transfer; the master waits for hready at each phase.
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= a;
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  // Reference pins: level is the event against polarity when enabled, else the data bit.
  task automatic model(output logic [11:0] oe, output logic [11:0] wl, output logic [11:0] db);
    logic en, dir, lvl;
    for (int i = 0; i < 12; i++) begin
      en = (i >= 8 && i <= 9) ? cfg[6 + i] : 1'b0;
      dir = dd[16 + i] | en;
      lvl = en ? ~(ev[i - 8] ^ cfg[4 + i]) : dd[i];
      oe[i] = dir & (cfg[i] | ~lvl);
      wl[i] = dir ? lvl : 1'b1;
      db[i] = dir ? dd[i] : 1'b1;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    logic [11:0] xoe, xwl, xdb;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    for (int r = 0; r < 2; r++) begin
      // The second pass starts with a reset in mid-run.
      if (r == 1) begin
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
      end
      // Reset values; undriven inputs read back high through the pull-ups.
      cfg = 32'h0000_3000;
      dd  = 32'h0000_0000;
      model(xoe, xwl, xdb);
      ahb(1'b0, 12'h1e0, 32'h0);
      chk("cfg reset", cfg, rd);
      ahb(1'b0, 12'h1e4, 32'h0);
      e = {dd[31:16], 4'h0, xdb};
      chk("dd reset", e, rd);
      chk("oe reset", {20'h0, xoe}, {20'h0, pin_oe});
      ahb(1'b1, 12'h1f0, 32'hffff_ffff);
      ahb(1'b0, 12'h1f0, 32'h0);
      chk("unmapped", 32'h0, rd);
      $display("test reset %0d done", r);
      for (int k = 0; k < 30; k++) begin
        cfg = $random(seed) & 32'h3fff_ffff;
        dd = $random(seed) & 32'h0fff_0fff;
        ahb(1'b1, 12'h1e0, cfg);
        ahb(1'b1, 12'h1e4, dd);
        for (int j = 0; j < 4; j++) begin
          @(posedge clk);
          ev <= j[1:0];
          repeat (3) @(posedge clk);
          #1;
          model(xoe, xwl, xdb);
          chk("pin oe", {20'h0, xoe}, {20'h0, pin_oe});
          chk("pin level", {20'h0, xwl}, {20'h0, pin_i});
        end
        ahb(1'b0, 12'h1e0, 32'h0);
        chk("cfg read", cfg, rd);
        ahb(1'b0, 12'h1e4, 32'h0);
        e = {dd[31:16], 4'h0, xdb};
        chk("dd read", e, rd);
      end
      $display("test random setups %0d done", r);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
